// *** verilog/voltage_detect_pkg.sv ***
package voltage_detect_pkg;

   // ==================================================
   // register addresses
   localparam logic [15:0] CTRL_ADDR = 16'hffbe;
   localparam logic [15:0] LEVEL_ADDR = 16'hffbf;

   // ==================================================
   // control and level register fields
   localparam int ENABLE_BIT = 7;
   localparam int SOURCE_BIT = 2;
   localparam int MODE_BIT = 1;
   localparam int FLAG_BIT = 0;
   localparam int LEVEL_W = 4;

   // ==================================================
   // reset values
   localparam logic CTRL_BIT_RESET = 1'b0;
   localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ==================================================
   // timing
   localparam int CLK_MHZ = 250;
   localparam int FILTER_TIME_US = 200;
   localparam int FILTER_CYCLES = FILTER_TIME_US * CLK_MHZ;
   localparam int FILTER_CNT_W = 16;

endpackage : voltage_detect_pkg

// *** verilog/below_level_filter.sv ***
`timescale 1ns/10ps
module below_level_filter #(
   parameter int CNT_W = voltage_detect_pkg::FILTER_CNT_W,
   parameter int FILTER_CYCLES = voltage_detect_pkg::FILTER_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic raw_below,
   output logic below_flag
);
   import voltage_detect_pkg::*;

   localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(FILTER_CYCLES - 1);

   logic sync1_reg;
   logic sync2_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic flag_reg;
   logic flag_next;

   // ==================================================
   // two-stage synchroniser
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= raw_below;
         sync2_reg <= sync1_reg;
      end
   end

   // ==================================================
   // qualify below level for the minimum time
   always_comb begin
      cnt_next = cnt_reg;
      flag_next = flag_reg;
      if (!enable || !sync2_reg) begin
         cnt_next = '0; // [RQ4]
         flag_next = 1'b0; // [RQ4]
      end else if (cnt_reg == LAST_CNT) begin
         flag_next = 1'b1; // [RQ7]
      end else begin
         cnt_next = cnt_reg + CNT_W'(1); // [RQ7]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         flag_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         flag_reg <= flag_next;
      end
   end

   assign below_flag = flag_reg;

endmodule : below_level_filter

// *** verilog/low_voltage_detect_control.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// [RQ1] both registers accept single-bit writes and whole byte writes
// [RQ2] control register clears to zero on any reset not from the detector
// [RQ3] enable, source and mode bits survive detector reset, clear otherwise
// [RQ4] bit 0 reads 1 while below threshold, 0 otherwise or when disabled
// [RQ5] enable bit 7 starts the comparator; clearing it stops it
// [RQ6] software waits up to 10 us after enabling before trusting results
// [RQ7] flag sets no sooner than 200 us after voltage drops below threshold
// [RQ8] bit 2 selects supply level (0) or external pin (1)
// [RQ9] mode 0 raises interrupt on both downward and upward crossings
// [RQ10] mode 1 holds internal reset while below threshold, releases above
// [RQ11] software stops detection by writing zero byte or clearing enable
// [RQ12] interrupt mode: disabling while below raises the interrupt
// [RQ13] level register bits 3..0 choose one of sixteen supply thresholds
// [RQ14] level register survives detector reset, clears on others
// [RQ15] software writes zeros to level register bits 7..4
// [RQ16] software leaves the level field alone while enabled
// [RQ17] external pin source uses a fixed threshold, level field ignored
// [RQ18] control bits 6..3 read zero and ignore writes
// [RQ19] a detector reset sets the detector reset cause flag
// [RQ20] any reset sets the detector interrupt mask flag
module low_voltage_detect_control #(
   parameter int FILTER_CYCLES = voltage_detect_pkg::FILTER_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic byte_wr,
   input wire logic [7:0] wdata,
   input wire logic bit_wr,
   input wire logic [2:0] bit_sel,
   input wire logic bit_val,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic comparator_below,
   input wire logic reset_cause_clear,
   output logic detector_enable,
   output logic source_select,
   output logic [voltage_detect_pkg::LEVEL_W-1:0] threshold_code,
   output logic detector_interrupt,
   output logic detector_reset,
   output logic detector_reset_cause_flag,
   output logic detector_irq_mask_set
);
   import voltage_detect_pkg::*;

   // ==================================================
   // register state and next values
   logic enable_reg;
   logic enable_next;
   logic source_reg;
   logic source_next;
   logic mode_reg;
   logic mode_next;
   logic [LEVEL_W-1:0] level_reg;
   logic [LEVEL_W-1:0] level_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic below_flag;
   logic prev_flag_reg;
   logic prev_enable_reg;
   logic irq_reg;
   logic irq_next;
   logic det_reset_reg;
   logic det_reset_next;
   logic cause_reg;
   logic cause_next;
   logic mask_set_reg;
   logic mask_set_next;
   logic prev_flag_next;
   logic prev_enable_next;
   logic ctrl_hit;
   logic level_hit;

   // ==================================================
   // address decode
   assign ctrl_hit = (addr == CTRL_ADDR);
   assign level_hit = (addr == LEVEL_ADDR);

   // ==================================================
   // register writes
   always_comb begin
      enable_next = enable_reg;
      source_next = source_reg;
      mode_next = mode_reg;
      level_next = level_reg;
      // byte write wins over a bit write in the same cycle
      // bit 0 and bits 6..3 have no storage, so writes there drop
      if (byte_wr && ctrl_hit) begin
         enable_next = wdata[ENABLE_BIT]; // [RQ1]
         source_next = wdata[SOURCE_BIT]; // [RQ1]
         mode_next = wdata[MODE_BIT]; // [RQ1]
      end else if (bit_wr && ctrl_hit) begin
         if (bit_sel == 3'(ENABLE_BIT)) begin
            enable_next = bit_val; // [RQ1]
         end
         if (bit_sel == 3'(SOURCE_BIT)) begin
            source_next = bit_val; // [RQ1]
         end
         if (bit_sel == 3'(MODE_BIT)) begin
            mode_next = bit_val; // [RQ1]
         end
      end
      if (byte_wr && level_hit) begin
         level_next = wdata[LEVEL_W-1:0]; // [RQ1]
      end else if (bit_wr && level_hit && bit_sel < 3'(LEVEL_W)) begin
         level_next[bit_sel[1:0]] = bit_val; // [RQ1]
      end
   end

   // only resets other than the detector's own reach these flops
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_reg <= CTRL_BIT_RESET; // [RQ2] [RQ3]
         source_reg <= CTRL_BIT_RESET; // [RQ3]
         mode_reg <= CTRL_BIT_RESET; // [RQ3]
         level_reg <= LEVEL_RESET; // [RQ14]
      end else begin
         enable_reg <= enable_next;
         source_reg <= source_next;
         mode_reg <= mode_next;
         level_reg <= level_next;
      end
   end

   // ==================================================
   // register reads
   always_comb begin
      // read data holds until the next read strobe
      rdata_next = rdata_reg;
      if (rd_en) begin
         // unmapped addresses read as zero
         rdata_next = 8'h00; // [RQ18]
         if (ctrl_hit) begin
            rdata_next[ENABLE_BIT] = enable_reg;
            rdata_next[SOURCE_BIT] = source_reg;
            rdata_next[MODE_BIT] = mode_reg;
            rdata_next[FLAG_BIT] = below_flag; // [RQ4]
         end else if (level_hit) begin
            rdata_next[LEVEL_W-1:0] = level_reg; // [RQ13]
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ==================================================
   // comparator result qualification
   below_level_filter #(
      .CNT_W(FILTER_CNT_W),
      .FILTER_CYCLES(FILTER_CYCLES)
   ) u_filter (
      .core_clk(core_clk),
      .rst(rst),
      .enable(enable_reg),
      .raw_below(comparator_below),
      .below_flag(below_flag)
   );

   // ==================================================
   // interrupt, internal reset and cause flag
   always_comb begin
      irq_next = 1'b0;
      prev_flag_next = below_flag;
      prev_enable_next = enable_reg;
      // interrupt mode: every change of the qualified flag
      if (!mode_reg) begin
         if (enable_reg && (below_flag != prev_flag_reg)) begin
            irq_next = 1'b1; // [RQ9]
         end
         if (prev_enable_reg && !enable_reg && prev_flag_reg) begin
            irq_next = 1'b1; // [RQ12]
         end
      end
      // reset mode: internal reset follows the flag
      det_reset_next = enable_reg && mode_reg && below_flag; // [RQ10]
      mask_set_next = det_reset_reg; // [RQ20]
      cause_next = cause_reg;
      if (reset_cause_clear) begin
         cause_next = 1'b0;
      end
      // a detector reset beats a software clear in the same cycle
      if (det_reset_reg) begin
         cause_next = 1'b1; // [RQ19]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_flag_reg <= 1'b0;
         prev_enable_reg <= 1'b0;
         irq_reg <= 1'b0;
         det_reset_reg <= 1'b0;
         cause_reg <= 1'b0;
         mask_set_reg <= 1'b1; // [RQ20]
      end else begin
         prev_flag_reg <= prev_flag_next;
         prev_enable_reg <= prev_enable_next;
         irq_reg <= irq_next;
         det_reset_reg <= det_reset_next;
         cause_reg <= cause_next;
         mask_set_reg <= mask_set_next;
      end
   end

   // ==================================================
   // outputs
   assign rdata = rdata_reg;
   assign detector_enable = enable_reg; // [RQ5]
   assign source_select = source_reg; // [RQ8] [RQ17]
   assign threshold_code = level_reg; // [RQ13]
   assign detector_interrupt = irq_reg;
   assign detector_reset = det_reset_reg;
   assign detector_reset_cause_flag = cause_reg;
   assign detector_irq_mask_set = mask_set_reg;

endmodule : low_voltage_detect_control

// *** verif/ldc_props.sv ***
`timescale 1ns/10ps
// ==========
// checker of port relations
module ldc_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic byte_wr,
   input wire logic [7:0] wdata,
   input wire logic bit_wr,
   input wire logic [2:0] bit_sel,
   input wire logic bit_val,
   input wire logic rd_en,
   input wire logic [7:0] rdata,
   input wire logic comparator_below,
   input wire logic detector_enable,
   input wire logic source_select,
   input wire logic [voltage_detect_pkg::LEVEL_W-1:0] threshold_code,
   input wire logic detector_interrupt,
   input wire logic detector_reset,
   input wire logic detector_reset_cause_flag,
   input wire logic detector_irq_mask_set
);
   import voltage_detect_pkg::*;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_mask_after_reset: assert property (detector_reset |=> detector_irq_mask_set)
      else $error("mask flag not set after detector reset");
   a_cause_flag_set: assert property (detector_reset |=> detector_reset_cause_flag)
      else $error("cause flag not set after detector reset");
   a_enable_byte_wr: assert property (byte_wr && addr == CTRL_ADDR
      |=> detector_enable == $past(wdata[7])) else $error("enable bit not written");
   a_source_bit_wr: assert property (bit_wr && !byte_wr && addr == CTRL_ADDR &&
      bit_sel == 3'h2 |=> source_select == $past(bit_val)) else $error("source bit not written");
   a_level_byte_wr: assert property (byte_wr && addr == LEVEL_ADDR
      |=> threshold_code == $past(wdata[3:0])) else $error("level field not written");
   a_ctrl_read_back: assert property (rd_en && addr == CTRL_ADDR
      |=> rdata[6:3] == 4'h0 && rdata[7] == $past(detector_enable)) else $error("bad ctrl read");
   a_flag_off_idle: assert property ((!detector_enable [*2]) ##0 (rd_en &&
      addr == CTRL_ADDR) |=> !rdata[0]) else $error("flag set while disabled");
   a_reset_needs_time: assert property ($rose(detector_reset)
      |-> $past(comparator_below, 3) && $past(comparator_below, 4)) else $error("reset too early");
   a_mask_on_reset: assert property ($fell(rst) |-> detector_irq_mask_set)
      else $error("mask flag not set by reset");
   a_reset_mode_quiet: assert property (detector_reset |-> !detector_interrupt)
      else $error("interrupt raised in reset mode");
endmodule : ldc_props
bind low_voltage_detect_control ldc_props u_ldc_props (
   .core_clk(core_clk),
   .rst(rst),
   .addr(addr),
   .byte_wr(byte_wr),
   .wdata(wdata),
   .bit_wr(bit_wr),
   .bit_sel(bit_sel),
   .bit_val(bit_val),
   .rd_en(rd_en),
   .rdata(rdata),
   .comparator_below(comparator_below),
   .detector_enable(detector_enable),
   .source_select(source_select),
   .threshold_code(threshold_code),
   .detector_interrupt(detector_interrupt),
   .detector_reset(detector_reset),
   .detector_reset_cause_flag(detector_reset_cause_flag),
   .detector_irq_mask_set(detector_irq_mask_set)
);

// *** verif/comparator_model.sv ***
`timescale 1ns/10ps
// ==========
// analog comparator stand-in
module comparator_model (
   input wire logic detector_enable,
   input wire logic source_select,
   input wire logic supply_low,
   input wire logic pin_low,
   output logic comparator_below
);
   // off comparator reports above; pin path ignores the level code
   assign comparator_below = detector_enable & (source_select ? pin_low : supply_low);
endmodule : comparator_model

// *** verif/low_voltage_detect_control_tb.sv ***
`timescale 1ns/10ps
module low_voltage_detect_control_tb;
   import voltage_detect_pkg::*;
   localparam int FC = 4;
   logic core_clk = 0, rst = 1, byte_wr = 0, bit_wr = 0, bit_val = 0, rd_en = 0;
   logic reset_cause_clear = 0, supply_low = 0, pin_low = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [7:0] rdata;
   logic [LEVEL_W-1:0] threshold_code;
   logic comparator_below, detector_enable, source_select, detector_interrupt;
   logic detector_reset, detector_reset_cause_flag, detector_irq_mask_set;
   int n_mismatch = 0, n_checks = 0, k;
   low_voltage_detect_control #(.FILTER_CYCLES(FC)) u_low_voltage_detect_control (
      .core_clk(core_clk),
      .rst(rst),
      .addr(addr),
      .byte_wr(byte_wr),
      .wdata(wdata),
      .bit_wr(bit_wr),
      .bit_sel(bit_sel),
      .bit_val(bit_val),
      .rd_en(rd_en),
      .rdata(rdata),
      .comparator_below(comparator_below),
      .reset_cause_clear(reset_cause_clear),
      .detector_enable(detector_enable),
      .source_select(source_select),
      .threshold_code(threshold_code),
      .detector_interrupt(detector_interrupt),
      .detector_reset(detector_reset),
      .detector_reset_cause_flag(detector_reset_cause_flag),
      .detector_irq_mask_set(detector_irq_mask_set)
   );
   comparator_model u_comparator_model (
      .detector_enable(detector_enable),
      .source_select(source_select),
      .supply_low(supply_low),
      .pin_low(pin_low),
      .comparator_below(comparator_below)
   );
   initial forever #2 core_clk = ~core_clk;
   // ==========
   // access tasks
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      byte_wr <= 1'b1;
      @(posedge core_clk);
      byte_wr <= 1'b0;
   endtask : wr
   task bw(input logic [15:0] a, input logic [2:0] s, input logic v);
      @(posedge core_clk);
      addr <= a;
      bit_sel <= s;
      bit_val <= v;
      bit_wr <= 1'b1;
      @(posedge core_clk);
      bit_wr <= 1'b0;
   endtask : bw
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd
   function automatic logic pick(input int s);
      return s == 0 ? detector_interrupt : s == 1 ? detector_reset : detector_reset_cause_flag;
   endfunction : pick
   task hold(input int s);
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while (k < 100 && !pick(s));
      chk(8'(pick(s)), 8'h01);
   endtask : hold
   task results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // ==========
   // tests
   initial begin
      repeat (5) @(posedge core_clk);
      #1 chk(8'(detector_irq_mask_set), 8'h01);
      @(posedge core_clk);
      rst <= 1'b0;
      rd(CTRL_ADDR, 8'h00);
      rd(LEVEL_ADDR, 8'h00);
      rd(16'h0000, 8'h00);
      $display("test 1 done");
      wr(CTRL_ADDR, 8'hff);
      rd(CTRL_ADDR, 8'h86);
      wr(CTRL_ADDR, 8'h00);
      wr(LEVEL_ADDR, 8'h0f);
      rd(LEVEL_ADDR, 8'h0f);
      bw(LEVEL_ADDR, 3'h3, 1'b0);
      rd(LEVEL_ADDR, 8'h07);
      chk(8'(threshold_code), 8'h07);
      bw(CTRL_ADDR, 3'h7, 1'b1);
      bw(CTRL_ADDR, 3'h2, 1'b1);
      rd(CTRL_ADDR, 8'h84);
      bw(CTRL_ADDR, 3'h7, 1'b0);
      rd(CTRL_ADDR, 8'h04);
      wr(CTRL_ADDR, 8'h00);
      $display("test 2 done");
      wr(LEVEL_ADDR, 8'h03);
      wr(CTRL_ADDR, 8'h80);
      repeat (2500) @(posedge core_clk);
      supply_low <= 1'b1;
      hold(0);
      chk(8'(k > FC), 8'h01);
      rd(CTRL_ADDR, 8'h81);
      @(posedge core_clk);
      supply_low <= 1'b0;
      hold(0);
      rd(CTRL_ADDR, 8'h80);
      @(posedge core_clk);
      supply_low <= 1'b1;
      hold(0);
      bw(CTRL_ADDR, 3'h7, 1'b0);
      hold(0);
      rd(CTRL_ADDR, 8'h00);
      @(posedge core_clk);
      supply_low <= 1'b0;
      $display("test 3 done");
      wr(CTRL_ADDR, 8'h84);
      repeat (2500) @(posedge core_clk);
      wr(CTRL_ADDR, 8'h86);
      @(posedge core_clk);
      pin_low <= 1'b1;
      hold(1);
      hold(2);
      chk(8'(detector_irq_mask_set), 8'h01);
      @(posedge core_clk);
      pin_low <= 1'b0;
      repeat (8) @(posedge core_clk);
      #1 chk(8'(detector_reset), 8'h00);
      rd(CTRL_ADDR, 8'h86);
      rd(LEVEL_ADDR, 8'h03);
      bw(CTRL_ADDR, 3'h1, 1'b0);
      bw(CTRL_ADDR, 3'h7, 1'b0);
      @(posedge core_clk);
      reset_cause_clear <= 1'b1;
      @(posedge core_clk);
      reset_cause_clear <= 1'b0;
      #1 chk(8'(detector_reset_cause_flag), 8'h00);
      wr(CTRL_ADDR, 8'h84);
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      #1 chk(8'(detector_irq_mask_set), 8'h01);
      @(posedge core_clk);
      rst <= 1'b0;
      rd(CTRL_ADDR, 8'h00);
      rd(LEVEL_ADDR, 8'h00);
      $display("test 4 done");
      results();
   end
   initial begin
      #100000;
      n_mismatch++;
      results();
   end
endmodule : low_voltage_detect_control_tb
